// >>> core/sidr_regs.sv
// Purpose: interrupt enable, breakpoint, line diagnostic and timer register bank
// Assumes: processor and host port buses are on mclk; sources are same-clock levels
// Notes: processor writes win over host-port writes in the same cycle
`timescale 1ns/10ps

module sidr_regs #(
    parameter logic [21:0] WDOG_CYC_P0 = 22'(sidr_pkg::WDOG_P0_US * 1000 / sidr_pkg::CLK_PERIOD_NS),
    parameter logic [21:0] WDOG_CYC_P1 = 22'(sidr_pkg::WDOG_P1_US * 1000 / sidr_pkg::CLK_PERIOD_NS),
    parameter logic [21:0] WDOG_CYC_P2 = 22'(sidr_pkg::WDOG_P2_US * 1000 / sidr_pkg::CLK_PERIOD_NS),
    parameter logic [21:0] WDOG_CYC_P3 = 22'(sidr_pkg::WDOG_P3_US * 1000 / sidr_pkg::CLK_PERIOD_NS)
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cpuSel,
    input wire logic cpuWrite,
    input wire logic [15:0] cpuAddr,
    input wire logic [15:0] cpuWdata,
    output logic [15:0] cpuRdata,
    input wire logic hpiSel,
    input wire logic hpiWrite,
    input wire logic [15:0] hpiAddr,
    input wire logic [15:0] hpiWdata,
    output logic [15:0] hpiRdata,
    input wire logic [15:0] pcValue,
    input wire logic [5:0] usb2IrqSrc,
    input wire logic [5:0] usb1IrqSrc,
    input wire logic [1:0] fastSerialIrqSrc,
    input wire logic incomingMailboxSrc,
    input wire logic outgoingMailboxSrc,
    input wire logic [1:0] serialIrqSrc,
    input wire logic gpioEvent,
    input wire logic gpioAck,
    input wire logic firstTimerAck,
    input wire logic secondTimerAck,
    output logic [5:0] usb2Irq,
    output logic [5:0] usb1Irq,
    output logic [1:0] fastSerialIrq,
    output logic incomingMailboxIrq,
    output logic outgoingMailboxIrq,
    output logic [1:0] serialIrq,
    output logic gpioIrq,
    output logic firstTimerIrq,
    output logic secondTimerIrq,
    output logic breakpointVector,
    output logic watchdogIrq,
    output logic cpuResetReq,
    output logic [1:0] diagForceEn,
    output logic [1:0] diagForceDp,
    output logic [1:0] diagForceDm,
    output logic [1:0] diagPulldownTest,
    output logic [1:0] diagLowspeedPullupTest,
    output logic [1:0] diagFullspeedPullupTest
);
    import sidr_pkg::*;

    typedef struct packed {
        logic [15:0] ieMask;
        logic [15:0] bpAddr;
        logic bpPend;
        logic [15:0] diag;
        logic gpioPend;
        logic t0Pend;
        logic t1Pend;
        logic [5:0] prescale;
        logic usTick;
        logic jkPhase;
        logic [15:0] cpuRdata;
        logic [15:0] hpiRdata;
    } sidr_state_t;

    sidr_state_t s_r;
    sidr_state_t s_nxt;

    logic wrEn;
    logic [15:0] wrAddr;
    logic [15:0] wrData;
    logic [15:0] tmr0Count;
    logic [15:0] tmr1Count;
    logic tmr0Zero;
    logic tmr1Zero;
    logic [15:0] wdogValue;
    logic wdogExpire;
    logic [1:0] portEn;
    logic bpMatch;

    // one write port; the processor wins a same-cycle collision
    always_comb begin
        wrEn = (cpuSel && cpuWrite) || (hpiSel && hpiWrite);
        wrAddr = (cpuSel && cpuWrite) ? cpuAddr : hpiAddr;
        wrData = (cpuSel && cpuWrite) ? cpuWdata : hpiWdata;
    end

    // read decode; unmapped addresses read as zero
    function automatic logic [15:0] readMux(input logic [15:0] addr, input logic fromHost);
        logic [15:0] v;
        v = 16'h0000;
        unique case (addr)
            ADDR_WDOG: v = wdogValue;
            ADDR_IE: v = s_r.ieMask;
            ADDR_TMR0: v = tmr0Count;
            ADDR_TMR1: v = tmr1Count;
            ADDR_BRK: v = s_r.bpAddr;
            ADDR_DIAG: v = fromHost ? 16'h0000 : s_r.diag;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : readMux

    // a zero address disarms the comparator, so writing zero can clear cleanly
    assign bpMatch = (pcValue == s_r.bpAddr) && (s_r.bpAddr != BRK_RESET);

    // register updates, pending flags and the microsecond prescaler
    always_comb begin
        s_nxt = s_r;
        s_nxt.usTick = 1'b0;
        if (s_r.prescale == TICK_CYC - 6'd1) begin
            s_nxt.prescale = 6'h00;
            s_nxt.usTick = 1'b1;
            s_nxt.jkPhase = ~s_r.jkPhase;
        end else begin
            s_nxt.prescale = s_r.prescale + 6'h01;
        end
        // reserved bits are masked, so stray ones from software do no harm
        if (wrEn && wrAddr == ADDR_IE) begin
            s_nxt.ieMask = (wrData & IE_WMASK) | (s_r.ieMask & ~IE_WMASK);
        end
        if (wrEn && wrAddr == ADDR_BRK) begin
            s_nxt.bpAddr = wrData;
            if (wrData == 16'h0000) begin
                s_nxt.bpPend = 1'b0;
            end
        end
        if (wrEn && wrAddr == ADDR_DIAG) begin
            s_nxt.diag = wrData & DIAG_WMASK;
        end
        // a hit in the clearing cycle still raises the vector
        if (bpMatch) begin
            s_nxt.bpPend = 1'b1;
        end
        // acknowledge loses to a new event; disable always wins
        if (gpioAck) s_nxt.gpioPend = 1'b0;
        if (firstTimerAck) s_nxt.t0Pend = 1'b0;
        if (secondTimerAck) s_nxt.t1Pend = 1'b0;
        if (gpioEvent) s_nxt.gpioPend = 1'b1;
        if (tmr0Zero) s_nxt.t0Pend = 1'b1;
        if (tmr1Zero) s_nxt.t1Pend = 1'b1;
        if (!s_nxt.ieMask[IE_GPIO]) s_nxt.gpioPend = 1'b0;
        if (!s_nxt.ieMask[IE_TMR1]) s_nxt.t1Pend = 1'b0;
        if (!s_nxt.ieMask[IE_TMR0]) s_nxt.t0Pend = 1'b0;
        s_nxt.cpuRdata = (cpuSel && !cpuWrite) ? readMux(cpuAddr, 1'b0) : s_r.cpuRdata;
        s_nxt.hpiRdata = (hpiSel && !hpiWrite) ? readMux(hpiAddr, 1'b1) : s_r.hpiRdata;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_r <= '{ieMask: IE_RESET, bpAddr: BRK_RESET, diag: DIAG_RESET, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    sidr_timer u_tmr0 (
        .mclk(mclk),
        .nrst(nrst),
        .usTick(s_r.usTick),
        .wrEn(wrEn && wrAddr == ADDR_TMR0),
        .wrData(wrData),
        .count(tmr0Count),
        .zeroPulse(tmr0Zero)
    );

    sidr_timer u_tmr1 (
        .mclk(mclk),
        .nrst(nrst),
        .usTick(s_r.usTick),
        .wrEn(wrEn && wrAddr == ADDR_TMR1),
        .wrData(wrData),
        .count(tmr1Count),
        .zeroPulse(tmr1Zero)
    );

    sidr_watchdog #(
        .CYC_P0(WDOG_CYC_P0),
        .CYC_P1(WDOG_CYC_P1),
        .CYC_P2(WDOG_CYC_P2),
        .CYC_P3(WDOG_CYC_P3)
    ) u_wdog (
        .mclk(mclk),
        .nrst(nrst),
        .wrEn(wrEn && wrAddr == ADDR_WDOG),
        .wrData(wrData),
        .regValue(wdogValue),
        .expirePulse(wdogExpire)
    );

    // source gating: source or pending flag and its enable; breakpoint and watchdog outputs pass ungated
    assign usb2Irq = usb2IrqSrc & {6{s_r.ieMask[IE_USB2]}};
    assign usb1Irq = usb1IrqSrc & {6{s_r.ieMask[IE_USB1]}};
    assign fastSerialIrq = fastSerialIrqSrc & {2{s_r.ieMask[IE_FSER]}};
    assign incomingMailboxIrq = incomingMailboxSrc && s_r.ieMask[IE_MBXIN];
    assign outgoingMailboxIrq = outgoingMailboxSrc && s_r.ieMask[IE_MBXOUT];
    assign serialIrq = serialIrqSrc & {2{s_r.ieMask[IE_SER]}};
    assign gpioIrq = s_r.gpioPend && s_r.ieMask[IE_GPIO];
    assign secondTimerIrq = s_r.t1Pend && s_r.ieMask[IE_TMR1];
    assign firstTimerIrq = s_r.t0Pend && s_r.ieMask[IE_TMR0];
    assign breakpointVector = s_r.bpPend;
    assign watchdogIrq = wdogExpire;
    assign cpuResetReq = wdogExpire;
    assign cpuRdata = s_r.cpuRdata;
    assign hpiRdata = s_r.hpiRdata;

    // line forcing per port; the toggle runs at half the microsecond tick
    assign portEn = {s_r.diag[DG_PORT2], s_r.diag[DG_PORT1]};
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            always_comb begin
                diagForceEn[p] = portEn[p];
                diagPulldownTest[p] = portEn[p] && s_r.diag[DG_PULLDN];
                diagLowspeedPullupTest[p] = portEn[p] && s_r.diag[DG_LSPU];
                diagFullspeedPullupTest[p] = portEn[p] && s_r.diag[DG_FSPU];
                unique casez (s_r.diag[DG_FSEL_HI:0])
                    3'b1??: begin
                        diagForceDp[p] = 1'b0;
                        diagForceDm[p] = 1'b0;
                    end
                    3'b01?: begin
                        diagForceDp[p] = s_r.jkPhase;
                        diagForceDm[p] = ~s_r.jkPhase;
                    end
                    3'b001: begin
                        diagForceDp[p] = 1'b1;
                        diagForceDm[p] = 1'b0;
                    end
                    3'b000: begin
                        diagForceDp[p] = 1'b0;
                        diagForceDm[p] = 1'b1;
                    end
                endcase
            end
        end
    endgenerate

    chk_usb2_mask: assert property (@(posedge mclk) disable iff (!nrst)
        wrEn && wrAddr == ADDR_IE && !wrData[IE_USB2] |=> usb2Irq == 6'h00)
        else $error("second engine interrupt passed while masked");
    chk_usb1_mask: assert property (@(posedge mclk) disable iff (!nrst)
        wrEn && wrAddr == ADDR_IE && wrData[IE_USB1] && usb1IrqSrc[0] |=> usb1Irq[0]
            || !usb1IrqSrc[0])
        else $error("first engine interrupt blocked while enabled");
    chk_gpio_discard: assert property (@(posedge mclk) disable iff (!nrst)
        wrEn && wrAddr == ADDR_IE && !wrData[IE_GPIO] |=> !s_r.gpioPend)
        else $error("pin pending survived disable");
    chk_timer_discard: assert property (@(posedge mclk) disable iff (!nrst)
        wrEn && wrAddr == ADDR_IE && !wrData[IE_TMR0] |=> !s_r.t0Pend ##1 !firstTimerIrq
            || tmr0Zero)
        else $error("first timer pending survived disable");
    chk_timer_raise: assert property (@(posedge mclk) disable iff (!nrst)
        tmr1Zero && s_r.ieMask[IE_TMR1] && !(wrEn && wrAddr == ADDR_IE) |=> secondTimerIrq)
        else $error("second timer event lost");
    chk_brk_raise: assert property (@(posedge mclk) disable iff (!nrst)
        bpMatch |=> breakpointVector)
        else $error("breakpoint match did not raise vector");
    chk_brk_hold: assert property (@(posedge mclk) disable iff (!nrst)
        breakpointVector && !(wrEn && wrAddr == ADDR_BRK && wrData == 16'h0000)
            |=> breakpointVector)
        else $error("breakpoint vector dropped without zero write");
    chk_brk_clear: assert property (@(posedge mclk) disable iff (!nrst)
        wrEn && wrAddr == ADDR_BRK && wrData == 16'h0000 && !bpMatch |=> !breakpointVector)
        else $error("zero write did not clear breakpoint");
    chk_diag_hostread: assert property (@(posedge mclk) disable iff (!nrst)
        hpiSel && !hpiWrite && hpiAddr == ADDR_DIAG |=> hpiRdata == 16'h0000)
        else $error("host port read the diagnostic register");
    chk_diag_force_j: assert property (@(posedge mclk) disable iff (!nrst)
        s_r.diag[DG_FSEL_HI:0] == 3'b001 |-> diagForceDp == 2'b11 && diagForceDm == 2'b00)
        else $error("force J not driven");
    chk_wdog_reset: assert property (@(posedge mclk) disable iff (!nrst)
        cpuResetReq |-> watchdogIrq ##1 wdogValue[WD_FLAG])
        else $error("watchdog expiry without flag");

    cov_brk_hit: cover property (@(posedge mclk) disable iff (!nrst)
        bpMatch ##1 breakpointVector);
    cov_wdog_expire: cover property (@(posedge mclk) disable iff (!nrst) cpuResetReq);
    cov_timer_fire: cover property (@(posedge mclk) disable iff (!nrst) firstTimerIrq);
    cov_diag_toggle: cover property (@(posedge mclk) disable iff (!nrst)
        diagForceEn[1] && s_r.diag[DG_FSEL_HI:1] == 2'b01);
endmodule : sidr_regs

// >>> core/sidr_pkg.sv
// Purpose: shared constants for the system control register bank
// Assumes: 16-bit register words at byte addresses, 40 MHz mclk
// Notes: period counts are derived in the top module from the times held here
package sidr_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_WDOG = 16'hc00c;
    localparam logic [15:0] ADDR_IE = 16'hc00e;
    localparam logic [15:0] ADDR_TMR0 = 16'hc010;
    localparam logic [15:0] ADDR_TMR1 = 16'hc012;
    localparam logic [15:0] ADDR_BRK = 16'hc014;
    localparam logic [15:0] ADDR_DIAG = 16'hc03c;

    // reset values and writable-bit masks
    localparam logic [15:0] IE_RESET = 16'h0010;
    localparam logic [15:0] IE_WMASK = 16'h1bef;
    localparam logic [15:0] BRK_RESET = 16'h0000;
    localparam logic [15:0] DIAG_RESET = 16'h0000;
    localparam logic [15:0] DIAG_WMASK = 16'h5077;
    localparam logic [15:0] TMR_RESET = 16'hffff;

    // interrupt enable bit positions
    localparam int IE_USB2 = 9;
    localparam int IE_USB1 = 8;
    localparam int IE_FSER = 7;
    localparam int IE_MBXIN = 6;
    localparam int IE_MBXOUT = 5;
    localparam int IE_SER = 3;
    localparam int IE_GPIO = 2;
    localparam int IE_TMR1 = 1;
    localparam int IE_TMR0 = 0;

    // diagnostic bit positions
    localparam int DG_PORT2 = 14;
    localparam int DG_PORT1 = 12;
    localparam int DG_PULLDN = 6;
    localparam int DG_LSPU = 5;
    localparam int DG_FSPU = 4;
    localparam int DG_FSEL_HI = 2;

    // watchdog bit positions
    localparam int WD_FLAG = 5;
    localparam int WD_PER_HI = 4;
    localparam int WD_PER_LO = 3;
    localparam int WD_LOCK = 2;
    localparam int WD_EN = 1;
    localparam int WD_STROBE = 0;

    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS = 1000;
    localparam logic [5:0] TICK_CYC = 6'(TICK_NS / CLK_PERIOD_NS);
    localparam int WDOG_P0_US = 1400;
    localparam int WDOG_P1_US = 5500;
    localparam int WDOG_P2_US = 22000;
    localparam int WDOG_P3_US = 66000;
    localparam int WDOG_CNT_W = 22;
endpackage : sidr_pkg

// >>> core/sidr_timer.sv
// Purpose: one 16-bit general timer counting down on the microsecond tick
// Assumes: usTick is a one-cycle pulse from the same clock
// Notes: a write reloads the count; zeroPulse fires once on reaching zero
`timescale 1ns/10ps
module sidr_timer (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic usTick,
    input wire logic wrEn,
    input wire logic [15:0] wrData,
    output logic [15:0] count,
    output logic zeroPulse
);
    import sidr_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic zero;
    } sidr_tmr_t;

    sidr_tmr_t s_r;
    sidr_tmr_t s_nxt;

    // a write wins over the tick so software always sees the value it loaded
    always_comb begin
        s_nxt = s_r;
        s_nxt.zero = 1'b0;
        if (wrEn) begin
            s_nxt.count = wrData;
        end else if (usTick && s_r.count != 16'h0000) begin
            s_nxt.count = s_r.count - 16'h0001;
            s_nxt.zero = (s_r.count == 16'h0001);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_r <= '{count: TMR_RESET, zero: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign count = s_r.count;
    assign zeroPulse = s_r.zero;

    chk_timer_zero: assert property (@(posedge mclk) disable iff (!nrst)
        usTick && !wrEn && count == 16'h0001 |=> zeroPulse && count == 16'h0000)
        else $error("timer did not signal zero");
endmodule : sidr_timer

// >>> core/sidr_watchdog.sv
// Purpose: watchdog with period select, lock, restart strobe and timeout flag
// Assumes: nrst is the external hardware reset, never the watchdog's own
// Notes: the timeout flag survives the processor reset it causes
`timescale 1ns/10ps
module sidr_watchdog #(
    parameter logic [21:0] CYC_P0 = 22'd56000,
    parameter logic [21:0] CYC_P1 = 22'd220000,
    parameter logic [21:0] CYC_P2 = 22'd880000,
    parameter logic [21:0] CYC_P3 = 22'd2640000
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wrEn,
    input wire logic [15:0] wrData,
    output logic [15:0] regValue,
    output logic expirePulse
);
    import sidr_pkg::*;

    typedef struct packed {
        logic lock;
        logic enable;
        logic [1:0] period;
        logic flag;
        logic [WDOG_CNT_W-1:0] count;
        logic expire;
    } sidr_wdog_t;

    sidr_wdog_t s_r;
    sidr_wdog_t s_nxt;
    logic [WDOG_CNT_W-1:0] limit;

    // period select to cycle count
    always_comb begin
        unique case (s_r.period)
            2'b00: limit = CYC_P0;
            2'b01: limit = CYC_P1;
            2'b10: limit = CYC_P2;
            2'b11: limit = CYC_P3;
        endcase
    end

    // counting first, then a write may restart or reconfigure
    always_comb begin
        s_nxt = s_r;
        s_nxt.expire = 1'b0;
        if (s_r.lock || s_r.enable) begin
            if (s_r.count >= limit - 22'd1) begin
                s_nxt.count = '0;
                s_nxt.expire = 1'b1;
                s_nxt.flag = 1'b1;
            end else begin
                s_nxt.count = s_r.count + 22'd1;
            end
        end else begin
            s_nxt.count = '0;
        end
        // once locked no write gets through, restart strobe included
        if (wrEn && !s_r.lock) begin
            s_nxt.enable = wrData[WD_EN];
            s_nxt.lock = wrData[WD_LOCK];
            s_nxt.period = wrData[WD_PER_HI:WD_PER_LO];
            if (wrData[WD_STROBE]) begin
                s_nxt.count = '0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // strobe reads back as zero, it is write-only
    assign regValue = {10'h000, s_r.flag, s_r.period, s_r.lock, s_r.enable, 1'b0};
    assign expirePulse = s_r.expire;

    chk_wdog_lock_holds: assert property (@(posedge mclk) disable iff (!nrst)
        s_r.lock && wrEn |=> $stable(regValue[WD_PER_HI:WD_EN]))
        else $error("locked watchdog accepted a write");
    chk_wdog_flag_sticks: assert property (@(posedge mclk) disable iff (!nrst)
        expirePulse |-> regValue[WD_FLAG] ##1 regValue[WD_FLAG][*3])
        else $error("timeout flag not held");
    chk_wdog_stopped: assert property (@(posedge mclk) disable iff (!nrst)
        !s_r.lock && !s_r.enable |=> !expirePulse)
        else $error("stopped watchdog expired");
endmodule : sidr_watchdog

// >>> tb/tb_sidr_regs.sv
// Purpose: self-checking bench for the system control register bank
// Assumes: watchdog periods shortened to 20/40/60/80 cycles
// Notes: each scenario drives the cpu or host port and judges the outputs itself
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_sidr_regs;
    import sidr_pkg::*;
    logic mclk = 1'b0, nrst = 1'b0, cpuSel = 1'b0, cpuWrite = 1'b0, hpiSel = 1'b0, hpiWrite = 1'b0;
    logic gpioEvent = 1'b0, gpioAck = 1'b0, firstTimerAck = 1'b0, secondTimerAck = 1'b0;
    logic [15:0] cpuAddr = '0, cpuWdata = '0, hpiAddr = '0, hpiWdata = '0, pcValue = '0;
    logic [15:0] cpuRdata, hpiRdata, v;
    logic [5:0] usb2IrqSrc = '1, usb1IrqSrc = '1, usb2Irq, usb1Irq;
    logic [1:0] fastSerialIrqSrc = '1, serialIrqSrc = '1, fastSerialIrq, serialIrq;
    logic incomingMailboxSrc = 1'b1, outgoingMailboxSrc = 1'b1, incomingMailboxIrq, outgoingMailboxIrq;
    logic gpioIrq, firstTimerIrq, secondTimerIrq, breakpointVector, watchdogIrq, cpuResetReq, b;
    logic [1:0] diagForceEn, diagForceDp, diagForceDm;
    logic [1:0] diagPulldownTest, diagLowspeedPullupTest, diagFullspeedPullupTest;
    logic [17:0] e;
    int mismatches = 0, compares = 0, cycles = 0, hits = 0, n;
    int bits [6] = '{9, 8, 7, 6, 5, 3};

    sidr_regs #(.WDOG_CYC_P0(22'd20), .WDOG_CYC_P1(22'd40), .WDOG_CYC_P2(22'd60),
        .WDOG_CYC_P3(22'd80)) i_dut (.mclk(mclk), .nrst(nrst), .cpuSel(cpuSel),
        .cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
        .hpiSel(hpiSel), .hpiWrite(hpiWrite), .hpiAddr(hpiAddr), .hpiWdata(hpiWdata),
        .hpiRdata(hpiRdata), .pcValue(pcValue), .usb2IrqSrc(usb2IrqSrc), .usb1IrqSrc(usb1IrqSrc),
        .fastSerialIrqSrc(fastSerialIrqSrc), .incomingMailboxSrc(incomingMailboxSrc),
        .outgoingMailboxSrc(outgoingMailboxSrc), .serialIrqSrc(serialIrqSrc),
        .gpioEvent(gpioEvent), .gpioAck(gpioAck), .firstTimerAck(firstTimerAck),
        .secondTimerAck(secondTimerAck), .usb2Irq(usb2Irq), .usb1Irq(usb1Irq),
        .fastSerialIrq(fastSerialIrq), .incomingMailboxIrq(incomingMailboxIrq),
        .outgoingMailboxIrq(outgoingMailboxIrq), .serialIrq(serialIrq), .gpioIrq(gpioIrq),
        .firstTimerIrq(firstTimerIrq), .secondTimerIrq(secondTimerIrq),
        .breakpointVector(breakpointVector), .watchdogIrq(watchdogIrq),
        .cpuResetReq(cpuResetReq), .diagForceEn(diagForceEn), .diagForceDp(diagForceDp),
        .diagForceDm(diagForceDm), .diagPulldownTest(diagPulldownTest),
        .diagLowspeedPullupTest(diagLowspeedPullupTest),
        .diagFullspeedPullupTest(diagFullspeedPullupTest));

    // clock, hang guard and watchdog pulse counter
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cpuResetReq === 1'b1) hits++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // every task returns on a rising edge, so all later drives land on an edge
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask : cyc

    // request held across the taking edge, released on it; read data still stands an edge later
    task automatic acc(input bit h, input bit w, input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        if (h) {hpiSel, hpiWrite, hpiAddr, hpiWdata} <= {1'b1, w, a, d};
        else {cpuSel, cpuWrite, cpuAddr, cpuWdata} <= {1'b1, w, a, d};
        @(posedge mclk);
        cpuSel <= 1'b0;
        hpiSel <= 1'b0;
        @(posedge mclk);
        v = h ? hpiRdata : cpuRdata;
    endtask : acc

    task automatic t_reset();
        acc(0, 0, ADDR_BRK, 16'h0); `CHK("brk", 16'h0000, v)
        acc(0, 0, ADDR_DIAG, 16'h0); `CHK("diag", 16'h0000, v)
        acc(0, 0, ADDR_WDOG, 16'h0); `CHK("wdog", 16'h0000, v)
        acc(0, 0, ADDR_TMR1, 16'h0); `CHK("tmr1", 16'hffff, v)
    endtask : t_reset

    // each source-group enable bit alone must open exactly its own group
    task automatic t_gate();
        acc(0, 1, ADDR_IE, 16'h0); `CHK("mask", 18'h0, {usb2Irq, usb1Irq, fastSerialIrq, incomingMailboxIrq, outgoingMailboxIrq, serialIrq})
        foreach (bits[i]) begin
            acc(0, 1, ADDR_IE, 16'h1 << bits[i]);
            e = bits[i] == 9 ? 18'h3f000 : bits[i] == 8 ? 18'h00fc0 : bits[i] == 7 ? 18'h00030 :
                bits[i] == 6 ? 18'h00008 : bits[i] == 5 ? 18'h00004 : 18'h00003;
            `CHK("gate", e, {usb2Irq, usb1Irq, fastSerialIrq, incomingMailboxIrq, outgoingMailboxIrq, serialIrq})
        end
        acc(0, 1, ADDR_IE, 16'h1bef);
        {usb2IrqSrc, usb1IrqSrc, fastSerialIrqSrc, serialIrqSrc} <= '0;
        cyc(1); `CHK("idle", 12'h0, {usb2Irq, usb1Irq})
        {usb2IrqSrc, usb1IrqSrc, fastSerialIrqSrc, serialIrqSrc} <= '1;
    endtask : t_gate

    task automatic t_pend();
        acc(0, 1, ADDR_IE, 16'h0007);
        acc(0, 1, ADDR_TMR0, 16'h0001);
        acc(0, 1, ADDR_TMR1, 16'h0002);
        for (n = 0; n < 130 && secondTimerIrq !== 1'b1; n++) cyc(1);
        `CHK("tmrs", 2'b11, {firstTimerIrq, secondTimerIrq})
        gpioEvent <= 1'b1;
        cyc(1); gpioEvent <= 1'b0;
        cyc(1); `CHK("gpio", 1'b1, gpioIrq)
        gpioAck <= 1'b1;
        cyc(1); gpioAck <= 1'b0; gpioEvent <= 1'b1;
        cyc(1); gpioEvent <= 1'b0;
        `CHK("gack", 1'b0, gpioIrq)
        cyc(1); `CHK("gpio2", 1'b1, gpioIrq)
        acc(0, 1, ADDR_IE, 16'h0); `CHK("off", 3'b000, {gpioIrq, firstTimerIrq, secondTimerIrq})
        acc(0, 1, ADDR_IE, 16'h0007); `CHK("drop", 3'b000, {gpioIrq, firstTimerIrq, secondTimerIrq})
    endtask : t_pend

    task automatic t_brk();
        acc(0, 1, ADDR_BRK, 16'h1234); `CHK("bpidle", 1'b0, breakpointVector)
        pcValue <= 16'h1234;
        cyc(1); pcValue <= 16'h0000;
        cyc(3); `CHK("bphold", 1'b1, breakpointVector)
        acc(0, 1, ADDR_BRK, 16'h0);
        cyc(1); `CHK("bpclr", 1'b0, breakpointVector)
    endtask : t_brk

    task automatic t_diag();
        acc(0, 1, ADDR_DIAG, 16'h5074);
        acc(0, 0, ADDR_DIAG, 16'h0); `CHK("dcpu", 16'h5074, v)
        acc(1, 0, ADDR_DIAG, 16'h0); `CHK("dhost", 16'h0000, v)
        `CHK("se0", 12'hc3f, {diagForceEn, diagForceDp, diagForceDm, diagPulldownTest, diagLowspeedPullupTest, diagFullspeedPullupTest})
        acc(1, 1, ADDR_DIAG, 16'h1001);
        acc(0, 0, ADDR_DIAG, 16'h0); `CHK("dhw", 16'h1001, v)
        `CHK("j", 8'h60, {diagForceEn, diagForceDp[0], diagForceDm[0], diagPulldownTest, diagLowspeedPullupTest})
        acc(0, 1, ADDR_DIAG, 16'h4000); `CHK("k", 4'h9, {diagForceEn, diagForceDp[1], diagForceDm[1]})
        acc(0, 1, ADDR_DIAG, 16'h4002);
        b = diagForceDp[1];
        for (n = 0; n < 45 && diagForceDp[1] === b; n++) cyc(1);
        `CHK("tog", 2'b10, {diagForceDp[1] !== b, diagForceDp[1] === diagForceDm[1]})
    endtask : t_diag

    task automatic t_wdog();
        acc(0, 1, ADDR_WDOG, 16'h0002);
        for (n = 0; n < 60 && cpuResetReq !== 1'b1; n++) cyc(1);
        `CHK("wdfire", 3'b111, {watchdogIrq, n >= 18, n <= 21})
        acc(0, 0, ADDR_WDOG, 16'h0); `CHK("wdflag", 16'h0022, v)
        n = hits;
        // kick first: the short period from the expiry above is still counting
        repeat (5) begin
            acc(0, 1, ADDR_WDOG, 16'h000b);
            cyc(25);
        end
        `CHK("wdkick", n, hits)
        acc(0, 1, ADDR_WDOG, 16'h0); cyc(100); `CHK("wdstop", n, hits)
        acc(0, 1, ADDR_WDOG, 16'h000c);
        acc(0, 1, ADDR_WDOG, 16'h0);
        acc(0, 0, ADDR_WDOG, 16'h0); `CHK("wdlock", 16'h002c, v)
        cyc(60); `CHK("wdrun", 1'b1, hits > n)
        nrst <= 1'b0;
        cyc(2); nrst <= 1'b1;
        acc(0, 0, ADDR_WDOG, 16'h0); `CHK("wdrst", 16'h0000, v)
    endtask : t_wdog

    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_gate();
        t_pend();
        t_brk();
        t_diag();
        t_wdog();
        stop_test();
    end
endmodule : tb_sidr_regs
